// ==== common/epo_params.svh ====
// Constants of the energy pulse output unit: register offsets, fields, reset values and timing.
// Notes on behaviour
// - After reset pin one gives total active, pin three total reactive, pin two energy sign.
// - Second selector: 0 sign, 1 total apparent pulses, 2 unused, 3 extended first selector.
// - Without extended mode third selector: reactive, power fail, voltage1 sign, apparent pulses.
// - Extended mode drives pins one and two per channel: active, apparent, reactive, wideband.
// - Extended mode third selector: 0 power fail, 1 sign of pins one and two, rest unused.
// - Total active and reactive sources read zero when below the no-load threshold.
// - A pulse lasts duration count sample periods of 250 us; the count resets to 1.
// - Sign and power-fail pins drive a steady level, ignoring pulse duration and rate.
// - Full-scale frequency is rate factor times sample rate over two, scaled by source value.
// - Total sources are the sum of both channels halved.
`ifndef EPO_PARAMS_SVH
`define EPO_PARAMS_SVH

// Byte offsets of the register words.
`define EPO_ADDR_MODE 12'h000
`define EPO_ADDR_DURATION 12'h004
`define EPO_ADDR_RATE 12'h008
`define EPO_ADDR_NOLOAD 12'h00C
`define EPO_ADDR_STATUS 12'h010

// Field positions in the mode word.
`define EPO_FIRST_LSB 0
`define EPO_SECOND_LSB 2
`define EPO_THIRD_LSB 4

// Reset values.
`define EPO_MODE_RESET 6'h00
`define EPO_DURATION_RESET 16'h0001
`define EPO_RATE_RESET 24'h100000
`define EPO_NOLOAD_RESET 23'h000000

// Timing: sample period in microseconds and clock period in nanoseconds.
`define EPO_SAMPLE_PERIOD_US 250
`define EPO_CLK_PERIOD_NS 10
`define EPO_SAMPLE_CYCLES ((`EPO_SAMPLE_PERIOD_US * 1000) / `EPO_CLK_PERIOD_NS)

`endif

// ==== common/epo_pkg.sv ====
// Types shared by the energy pulse output unit.
package epo_pkg;

    // Power results of both measurement channels, signed fractions, and the voltage1 sign flag.
    typedef struct packed {
        logic signed [23:0] active1;
        logic signed [23:0] active2;
        logic signed [23:0] apparent1;
        logic signed [23:0] apparent2;
        logic signed [23:0] reactive1;
        logic signed [23:0] reactive2;
        logic signed [23:0] wideband1;
        logic signed [23:0] wideband2;
        logic voltage1Negative;
    } epo_energy_t;

    // What a pin shows.
    typedef enum logic [1:0] {
        EPO_KIND_IDLE = 2'b00,
        EPO_KIND_PULSE = 2'b01,
        EPO_KIND_LEVEL = 2'b10
    } epo_kind_t;

    // APB request and answer.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } epo_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } epo_apb_rsp_t;

endpackage : epo_pkg

// ==== verilog/epo_sync2.sv ====
// Two-stage synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module epo_sync2 import epo_pkg::*; #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } epo_sync_state_t;

    epo_sync_state_t q, d;

    // Refuse widths that the logic cannot serve.
    if (WIDTH < 1) begin : g_bad_width
        $error("epo_sync2: WIDTH must be at least 1.");
    end

    // The first stage feeds only the second stage.
    always_comb begin
        d = q;
        d.stage1 = asyncIn;
        d.stage2 = q.stage1;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign syncOut = q.stage2;
endmodule : epo_sync2
`default_nettype wire

// ==== verilog/epo_pulse_channel.sv ====
// One pulse channel: rate accumulator and pulse duration counter.
`timescale 1ns/1ps
`default_nettype none
module epo_pulse_channel import epo_pkg::*; #(
    parameter int MAG_W = 23,
    parameter int RATE_W = 24,
    parameter int DUR_W = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic tick,
    input wire logic enable,
    input wire logic [MAG_W-1:0] srcMag,
    input wire logic [RATE_W-1:0] rate,
    input wire logic [DUR_W-1:0] duration,
    output logic pulseActive
);
    localparam int ACC_W = MAG_W + RATE_W + 1;

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic [DUR_W-1:0] widthCnt;
        logic pending;
    } epo_chan_state_t;

    epo_chan_state_t q, d;
    logic [ACC_W:0] sum;
    logic [MAG_W+RATE_W-1:0] product;
    logic overflow;
    logic [DUR_W-1:0] effDuration;

    // Refuse widths that the logic cannot serve.
    if (MAG_W < 1 || RATE_W < 1 || DUR_W < 1) begin : g_bad_widths
        $error("epo_pulse_channel: widths must be positive.");
    end

    // A zero duration still yields a one-tick pulse.
    assign effDuration = (duration == '0) ? {{(DUR_W-1){1'b0}}, 1'b1} : duration;
    // The product carries one bit less than the accumulator, which halves the full-scale rate.
    assign product = {{RATE_W{1'b0}}, srcMag} * {{MAG_W{1'b0}}, rate};
    assign sum = {1'b0, q.acc} + {2'b00, product};
    assign overflow = sum[ACC_W];

    // Accumulate on each tick; a carry out starts a pulse or queues one behind the running pulse.
    always_comb begin
        d = q;
        if (!enable) begin
            d = '0;
        end else if (tick) begin
            d.acc = sum[ACC_W-1:0];
            if (q.widthCnt != '0) begin
                d.widthCnt = q.widthCnt - {{(DUR_W-1){1'b0}}, 1'b1};
            end
            if (overflow) begin
                if (q.widthCnt == '0) begin
                    d.widthCnt = effDuration;
                end else begin
                    d.pending = 1'b1;
                end
            end else if (q.widthCnt == '0 && q.pending) begin
                d.widthCnt = effDuration;
                d.pending = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign pulseActive = (q.widthCnt != '0);

    property p_pulse_start;
        @(posedge clk) disable iff (srst)
        (ce && enable && tick && overflow && q.widthCnt == '0) |=> (q.widthCnt == $past(effDuration));
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("Pulse did not start with its duration.");

    property p_pulse_count;
        @(posedge clk) disable iff (srst)
        (ce && enable && tick && q.widthCnt > 1 && !overflow) |=> (q.widthCnt == $past(q.widthCnt) - 1);
    endproperty
    a_pulse_count: assert property (p_pulse_count) else $error("Pulse duration did not count down per tick.");

    property p_idle_clear;
        @(posedge clk) disable iff (srst)
        (ce && !enable) |=> (!pulseActive && q.acc == '0);
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("Disabled channel kept pulse state.");
endmodule : epo_pulse_channel
`default_nettype wire

// ==== verilog/epo_energy_pulse_unit.sv ====
// Energy pulse output unit: APB registers, source selection, pin functions and three pulse channels.
`timescale 1ns/1ps
`default_nettype none
`include "epo_params.svh"
module epo_energy_pulse_unit import epo_pkg::*; #(
    parameter int SAMPLE_CYCLES = `EPO_SAMPLE_CYCLES,
    parameter int DUR_W = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire epo_apb_req_t apbReq,
    output epo_apb_rsp_t apbRsp,
    input wire epo_energy_t energyIn,
    input wire logic powerFailMonitor,
    output logic pulseOutFirstN,
    output logic pulseOutSecondN,
    output logic pulseOutThirdN,
    output logic sampleTick
);
    typedef struct packed {
        logic [1:0] firstPinSelect;
        logic [1:0] secondPinSelect;
        logic [1:0] thirdPinSelect;
        logic [DUR_W-1:0] pulseDurationCount;
        logic [23:0] fullScaleFrequencyFactor;
        logic [22:0] noLoadThreshold;
        logic [31:0] prdata;
        logic [31:0] tickCnt;
        logic tick;
        logic firstN;
        logic secondN;
        logic thirdN;
    } epo_top_state_t;

    epo_top_state_t q, d;
    logic powerFailSync;
    logic extMode;
    logic signed [23:0] totalActive, totalApparent, totalReactive;
    logic [22:0] activeMag, apparentMag, reactiveMag, firstMag, secondMag, thirdMag;
    logic activeNeg, reactiveNeg, firstNeg, secondNeg;
    epo_kind_t firstKind, secondKind, thirdKind;
    logic secondLevelN, thirdLevelN;
    logic [2:0] pulseActive;
    logic setupPhase, accessPhase, addrHit;
    logic [31:0] readValue;

    if (SAMPLE_CYCLES < 2 || DUR_W < 1 || DUR_W > 32) begin : g_bad_params
        $error("epo_energy_pulse_unit: SAMPLE_CYCLES must be at least 2 and DUR_W 1 to 32.");
    end

    // Magnitude of a signed fraction, saturating the most negative code.
    function automatic logic [22:0] epo_mag(input logic signed [23:0] v);
        logic [23:0] neg;
        neg = 24'h000000 - v;
        if (!v[23]) begin
            epo_mag = v[22:0];
        end else if (neg[23]) begin
            epo_mag = 23'h7FFFFF;
        end else begin
            epo_mag = neg[22:0];
        end
    endfunction : epo_mag

    // Sum of both channels, halved.
    function automatic logic signed [23:0] epo_half_sum(input logic signed [23:0] a, input logic signed [23:0] b);
        logic signed [24:0] s;
        s = {a[23], a} + {b[23], b};
        epo_half_sum = s[24:1];
    endfunction : epo_half_sum

    epo_sync2 #(
        .WIDTH(1)
    ) u_pf_sync (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .asyncIn(powerFailMonitor),
        .syncOut(powerFailSync)
    );

    // Totals of the two channels and the no-load cut on active and reactive totals.
    always_comb begin
        totalActive = epo_half_sum(energyIn.active1, energyIn.active2);
        totalApparent = epo_half_sum(energyIn.apparent1, energyIn.apparent2);
        totalReactive = epo_half_sum(energyIn.reactive1, energyIn.reactive2);
        activeMag = epo_mag(totalActive);
        if (activeMag < q.noLoadThreshold) begin
            activeMag = '0;
        end
        reactiveMag = epo_mag(totalReactive);
        if (reactiveMag < q.noLoadThreshold) begin
            reactiveMag = '0;
        end
        apparentMag = epo_mag(totalApparent);
        activeNeg = totalActive[23] && (activeMag != '0);
        reactiveNeg = totalReactive[23] && (reactiveMag != '0);
    end

    assign extMode = (q.secondPinSelect == 2'b11);

    // Sources and functions of the first two pins.
    always_comb begin
        firstMag = activeMag;
        firstNeg = activeNeg;
        secondMag = '0;
        secondNeg = 1'b0;
        firstKind = EPO_KIND_PULSE;
        secondKind = EPO_KIND_IDLE;
        secondLevelN = 1'b1;
        if (extMode) begin
            secondKind = EPO_KIND_PULSE;
            case (q.firstPinSelect)
                2'b00: begin
                    firstMag = epo_mag(energyIn.active1);
                    firstNeg = energyIn.active1[23];
                    secondMag = epo_mag(energyIn.active2);
                    secondNeg = energyIn.active2[23];
                end
                2'b01: begin
                    firstMag = epo_mag(energyIn.apparent1);
                    firstNeg = energyIn.apparent1[23];
                    secondMag = epo_mag(energyIn.apparent2);
                    secondNeg = energyIn.apparent2[23];
                end
                2'b10: begin
                    firstMag = epo_mag(energyIn.reactive1);
                    firstNeg = energyIn.reactive1[23];
                    secondMag = epo_mag(energyIn.reactive2);
                    secondNeg = energyIn.reactive2[23];
                end
                default: begin
                    firstMag = epo_mag(energyIn.wideband1);
                    firstNeg = energyIn.wideband1[23];
                    secondMag = epo_mag(energyIn.wideband2);
                    secondNeg = energyIn.wideband2[23];
                end
            endcase
        end else begin
            case (q.secondPinSelect)
                2'b00: begin
                    secondKind = EPO_KIND_LEVEL;
                    secondLevelN = !(activeNeg || reactiveNeg);
                end
                2'b01: begin
                    secondKind = EPO_KIND_PULSE;
                    secondMag = apparentMag;
                end
                default: begin
                    secondKind = EPO_KIND_IDLE;
                end
            endcase
        end
    end

    // Source and function of the third pin.
    always_comb begin
        thirdMag = '0;
        thirdKind = EPO_KIND_IDLE;
        thirdLevelN = 1'b1;
        if (extMode) begin
            case (q.thirdPinSelect)
                2'b00: begin
                    thirdKind = EPO_KIND_LEVEL;
                    thirdLevelN = !powerFailSync;
                end
                2'b01: begin
                    thirdKind = EPO_KIND_LEVEL;
                    thirdLevelN = !(firstNeg || secondNeg);
                end
                default: begin
                    thirdKind = EPO_KIND_IDLE;
                end
            endcase
        end else begin
            case (q.thirdPinSelect)
                2'b00: begin
                    thirdKind = EPO_KIND_PULSE;
                    thirdMag = reactiveMag;
                end
                2'b01: begin
                    thirdKind = EPO_KIND_LEVEL;
                    thirdLevelN = !powerFailSync;
                end
                2'b10: begin
                    thirdKind = EPO_KIND_LEVEL;
                    thirdLevelN = !energyIn.voltage1Negative;
                end
                default: begin
                    thirdKind = EPO_KIND_PULSE;
                    thirdMag = apparentMag;
                end
            endcase
        end
    end

    epo_pulse_channel #(.MAG_W(23), .RATE_W(24), .DUR_W(DUR_W)) u_chan_first (
        .clk(clk), .srst(srst), .ce(ce), .tick(q.tick),
        .enable(firstKind == EPO_KIND_PULSE),
        .srcMag(firstMag), .rate(q.fullScaleFrequencyFactor),
        .duration(q.pulseDurationCount), .pulseActive(pulseActive[0])
    );
    epo_pulse_channel #(.MAG_W(23), .RATE_W(24), .DUR_W(DUR_W)) u_chan_second (
        .clk(clk), .srst(srst), .ce(ce), .tick(q.tick),
        .enable(secondKind == EPO_KIND_PULSE),
        .srcMag(secondMag), .rate(q.fullScaleFrequencyFactor),
        .duration(q.pulseDurationCount), .pulseActive(pulseActive[1])
    );
    epo_pulse_channel #(.MAG_W(23), .RATE_W(24), .DUR_W(DUR_W)) u_chan_third (
        .clk(clk), .srst(srst), .ce(ce), .tick(q.tick),
        .enable(thirdKind == EPO_KIND_PULSE),
        .srcMag(thirdMag), .rate(q.fullScaleFrequencyFactor),
        .duration(q.pulseDurationCount), .pulseActive(pulseActive[2])
    );

    // APB decode and read mux.
    assign setupPhase = apbReq.psel && !apbReq.penable;
    assign accessPhase = apbReq.psel && apbReq.penable;
    always_comb begin
        addrHit = 1'b1;
        readValue = 32'h00000000;
        case (apbReq.paddr)
            `EPO_ADDR_MODE: begin
                readValue[`EPO_FIRST_LSB +: 2] = q.firstPinSelect;
                readValue[`EPO_SECOND_LSB +: 2] = q.secondPinSelect;
                readValue[`EPO_THIRD_LSB +: 2] = q.thirdPinSelect;
            end
            `EPO_ADDR_DURATION: readValue[DUR_W-1:0] = q.pulseDurationCount;
            `EPO_ADDR_RATE: readValue[23:0] = q.fullScaleFrequencyFactor;
            `EPO_ADDR_NOLOAD: readValue[22:0] = q.noLoadThreshold;
            `EPO_ADDR_STATUS: readValue[3:0] = {powerFailSync, q.thirdN, q.secondN, q.firstN};
            default: addrHit = 1'b0;
        endcase
    end

    // Register writes, sample tick generation and registered pin levels.
    always_comb begin
        d = q;
        if (setupPhase) begin
            d.prdata = readValue;
        end
        if (accessPhase && apbReq.pwrite && addrHit) begin
            case (apbReq.paddr)
                `EPO_ADDR_MODE: begin
                    d.firstPinSelect = apbReq.pwdata[`EPO_FIRST_LSB +: 2];
                    d.secondPinSelect = apbReq.pwdata[`EPO_SECOND_LSB +: 2];
                    d.thirdPinSelect = apbReq.pwdata[`EPO_THIRD_LSB +: 2];
                end
                `EPO_ADDR_DURATION: d.pulseDurationCount = apbReq.pwdata[DUR_W-1:0];
                `EPO_ADDR_RATE: d.fullScaleFrequencyFactor = apbReq.pwdata[23:0];
                `EPO_ADDR_NOLOAD: d.noLoadThreshold = apbReq.pwdata[22:0];
                default: d.prdata = q.prdata;
            endcase
        end
        d.tick = (q.tickCnt == 32'(SAMPLE_CYCLES - 1));
        d.tickCnt = d.tick ? 32'h00000000 : q.tickCnt + 32'h00000001;
        d.firstN = !pulseActive[0];
        d.secondN = (secondKind == EPO_KIND_PULSE) ? !pulseActive[1] : secondLevelN;
        d.thirdN = (thirdKind == EPO_KIND_PULSE) ? !pulseActive[2] : thirdLevelN;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
            {q.thirdPinSelect, q.secondPinSelect, q.firstPinSelect} <= `EPO_MODE_RESET;
            q.pulseDurationCount <= DUR_W'(`EPO_DURATION_RESET);
            q.fullScaleFrequencyFactor <= `EPO_RATE_RESET;
            q.noLoadThreshold <= `EPO_NOLOAD_RESET;
            q.firstN <= 1'b1;
            q.secondN <= 1'b1;
            q.thirdN <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    assign apbRsp.pready = 1'b1;
    assign apbRsp.pslverr = accessPhase && !addrHit;
    assign apbRsp.prdata = q.prdata;
    assign pulseOutFirstN = q.firstN;
    assign pulseOutSecondN = q.secondN;
    assign pulseOutThirdN = q.thirdN;
    assign sampleTick = q.tick;

    property p_reset_defaults;
        @(posedge clk) srst |=> (q.secondPinSelect == 2'b00 && q.thirdPinSelect == 2'b00
            && q.pulseDurationCount == 1 && firstKind == EPO_KIND_PULSE && thirdKind == EPO_KIND_PULSE);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("Reset did not give default pin map.");

    property p_unused_second;
        @(posedge clk) disable iff (srst)
        (ce && q.secondPinSelect == 2'b10) ##1 (ce && q.secondPinSelect == 2'b10) |-> pulseOutSecondN;
    endproperty
    a_unused_second: assert property (p_unused_second) else $error("Unused second pin was not high.");

    property p_apparent_second;
        @(posedge clk) disable iff (srst)
        (q.secondPinSelect == 2'b01) |-> (secondKind == EPO_KIND_PULSE && secondMag == epo_mag(totalApparent));
    endproperty
    a_apparent_second: assert property (p_apparent_second) else $error("Second pin not on apparent total.");

    property p_power_fail_third;
        @(posedge clk) disable iff (srst)
        (ce && !extMode && q.thirdPinSelect == 2'b01) |=> (pulseOutThirdN == !$past(powerFailSync));
    endproperty
    a_power_fail_third: assert property (p_power_fail_third) else $error("Third pin not on power fail level.");

    property p_ext_first;
        @(posedge clk) disable iff (srst)
        (extMode && q.firstPinSelect == 2'b10) |-> (firstMag == epo_mag(energyIn.reactive1)
            && secondMag == epo_mag(energyIn.reactive2));
    endproperty
    a_ext_first: assert property (p_ext_first) else $error("Extended mode not on per-channel reactive.");

    property p_ext_third_sign;
        @(posedge clk) disable iff (srst)
        (ce && extMode && q.thirdPinSelect == 2'b01) |=> (pulseOutThirdN == !($past(firstNeg) || $past(secondNeg)));
    endproperty
    a_ext_third_sign: assert property (p_ext_third_sign) else $error("Third pin not on sign of pins one and two.");

    property p_no_load;
        @(posedge clk) disable iff (srst)
        (epo_mag(totalActive) < q.noLoadThreshold) |-> (activeMag == '0);
    endproperty
    a_no_load: assert property (p_no_load) else $error("Active source not cut below no-load threshold.");

    property p_half_sum;
        @(posedge clk) disable iff (srst)
        1'b1 |-> ({totalActive, 1'b0} == (({energyIn.active1[23], energyIn.active1}
            + {energyIn.active2[23], energyIn.active2}) & 25'h1FFFFFE));
    endproperty
    a_half_sum: assert property (p_half_sum) else $error("Active total is not the halved sum.");

    property p_tick_period;
        @(posedge clk) disable iff (srst)
        (ce && q.tick) |=> !q.tick;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("Sample tick lasted more than one cycle.");
endmodule : epo_energy_pulse_unit
`default_nettype wire

// ==== tb/epo_pulse_counter_model.sv ====
// Meter-side pulse counter that counts falling edges and measures low widths of the second pin.
`timescale 1ns/1ps
`default_nettype none
module epo_pulse_counter_model (
    input wire logic clk,
    input wire logic clear,
    input wire logic [2:0] pinN,
    output logic [47:0] falls,
    output logic [31:0] lowLen
);
    logic [2:0] prevQ;
    logic [31:0] runQ;
    // Counts one pulse per falling edge and times how long the second pin stays low.
    always_ff @(posedge clk) begin
        prevQ <= pinN;
        for (int i = 0; i < 3; i++) begin
            if (clear) begin
                falls[16*i+:16] <= 16'h0000;
            end else if (prevQ[i] && !pinN[i]) begin
                falls[16*i+:16] <= falls[16*i+:16] + 16'h0001;
            end
        end
        runQ <= pinN[1] ? 32'h0 : runQ + 32'h1;
        if (pinN[1] && !prevQ[1]) begin
            lowLen <= runQ;
        end
    end
endmodule : epo_pulse_counter_model
`default_nettype wire

// ==== tb/tb.sv ====
// Testbench of the energy pulse output unit: APB register access and pin behaviour.
`timescale 1ns/1ps
`default_nettype none
`include "epo_params.svh"
module tb import epo_pkg::*;;
    localparam int SC = 10;
    logic clk = 1'b0;
    logic srst, ce, pfm, clr, tick, e;
    logic [2:0] pin;
    logic [47:0] falls;
    logic [31:0] lowLen, d;
    epo_apb_req_t req;
    epo_apb_rsp_t rsp;
    epo_energy_t en;
    int mismatches, checks_done;
    epo_energy_pulse_unit #(.SAMPLE_CYCLES(SC), .DUR_W(16)) epo_energy_pulse_unit_i (.clk(clk), .srst(srst),
        .ce(ce), .apbReq(req), .apbRsp(rsp), .energyIn(en), .powerFailMonitor(pfm), .pulseOutFirstN(pin[0]),
        .pulseOutSecondN(pin[1]), .pulseOutThirdN(pin[2]), .sampleTick(tick));
    epo_pulse_counter_model epo_pulse_counter_model_i (.clk(clk), .clear(clr), .pinN(pin), .falls(falls),
        .lowLen(lowLen));
    // The clock toggles every half period.
    always #5 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1) begin
            @(posedge clk);
        end
        d = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
        @(posedge clk); // An idle edge keeps the next request apart from this one.
    endtask : apb
    task automatic ticks(input int n);
        clr <= 1'b1;
        w(1);
        clr <= 1'b0;
        while (n > 0) begin
            @(posedge clk);
            if (tick === 1'b1) n--;
        end
        w(3);
    endtask : ticks
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    // The watchdog cuts a hang short.
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
    // Main sequence of scenarios.
    initial begin
        srst = 1; ce = 1; pfm = 0; clr = 1; req = '0; en = '0;
        en.active1 = 24'h400000; en.active2 = 24'h400000; en.reactive1 = 24'h100000; en.reactive2 = 24'h100000;
        en.apparent1 = 24'h7FFFFF; en.apparent2 = 24'h000001;
        w(5);
        srst <= 1'b0;
        apb(0, `EPO_ADDR_MODE, 0); chk("mode", d, 32'h0);
        apb(0, `EPO_ADDR_DURATION, 0); chk("duration", d, 32'h1);
        apb(0, `EPO_ADDR_RATE, 0); chk("rate", d, 32'h100000);
        apb(0, `EPO_ADDR_NOLOAD, 0); chk("noload", d, 32'h0);
        apb(0, 12'h020, 0); chk("unmapped", {e, d[30:0]}, 32'h80000000);
        w(5); chk("sign pos", pin[1], 1);
        en.reactive1 <= 24'hF00000; en.reactive2 <= 24'hF00000;
        w(5); chk("sign neg", pin[1], 0);
        apb(1, `EPO_ADDR_MODE, 32'h08); w(5); chk("second unused", pin[1], 1);
        apb(1, `EPO_ADDR_RATE, 32'h800000);
        apb(1, `EPO_ADDR_MODE, 32'h04);
        ticks(44); chk("apparent pulses", falls[31:16], 16'(((44 * 64'h400000 * 64'h800000) >> 48)));
        apb(1, `EPO_ADDR_DURATION, 2); ticks(20); chk("width", lowLen, 2 * SC);
        apb(1, `EPO_ADDR_NOLOAD, 32'h500000); ticks(20); chk("noload", falls[15:0], 0);
        // A reset in mid-run restores duration and threshold and clears every accumulator.
        srst <= 1'b1; w(2); srst <= 1'b0;
        apb(0, `EPO_ADDR_DURATION, 0); chk("duration after reset", d, 32'h1);
        apb(1, `EPO_ADDR_RATE, 32'h800000); apb(1, `EPO_ADDR_MODE, 32'h1D);
        ticks(20); chk("ch1 apparent", falls[15:0], 4); chk("ch2 apparent", falls[31:16], 0);
        en.apparent2 <= 24'hC00000; w(5); chk("ext sign", pin[2], 0);
        apb(1, `EPO_ADDR_MODE, 32'h2C); w(5); chk("ext unused", pin[2], 1);
        pfm <= 1'b1;
        apb(1, `EPO_ADDR_MODE, 32'h0C); w(6); chk("ext power fail", pin[2], 0);
        apb(1, `EPO_ADDR_MODE, 32'h10); w(6); chk("power fail", pin[2], 0);
        apb(0, `EPO_ADDR_STATUS, 0); chk("status", d[3:1], 3'b100);
        pfm <= 1'b0; w(6); chk("power ok", pin[2], 1);
        en.voltage1Negative <= 1'b1;
        apb(1, `EPO_ADDR_MODE, 32'h20); w(5); chk("voltage1 sign", pin[2], 0);
        // With the clock enable low the pin keeps its level although its source changes.
        ce <= 1'b0; en.voltage1Negative <= 1'b0;
        w(5); chk("frozen pin", pin[2], 0);
        ce <= 1'b1;
        w(5); chk("thawed pin", pin[2], 1);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
